/* src/pmcs_top.sv */
// power mode controller and clock source switcher with APB registers
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int unsigned OST_LEN = OST_CYCLES
) (
  input wire logic pclk, // 50 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output var logic [31:0] prdata, // apb read data
  output var logic pready, // apb ready
  output var logic pslverr, // apb error, unmapped address
  input wire logic halt_req, // halt instruction, one-cycle pulse
  input wire logic wake_event, // interrupt, reset or watchdog wake pulse
  input wire logic pri_osc_tick, // primary oscillator, async pin
  input wire logic sec_osc_tick, // secondary oscillator, async pin
  input wire logic int_osc_tick, // internal oscillator, async pin
  input wire logic sec_osc_running, // secondary oscillating, async pin
  output var logic cpu_clk_en, // cpu clock gate
  output var logic periph_clk_en, // peripheral clock gate
  output var logic [1:0] clk_source, // source on the clock mux
  output var logic pri_osc_en, // primary oscillator run
  output var logic sec_osc_en, // secondary oscillator run
  output var logic int_osc_en, // internal oscillator run
  output var logic primary_clock_active, // status copy
  output var logic secondary_clock_active // status copy
);
  localparam int unsigned OW = $clog2(OST_LEN);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic idle_on_halt;
  logic [1:0] clock_source_select;
  logic secondary_osc_enable;
  logic [4:0] cfg_reg;
  pmcs_state_t state_reg, state_next;
  pmcs_src_t cur_reg, cur_next, dest_reg, dest_next, tgt;
  logic [1:0] pcnt_reg, pcnt_next;
  logic [OW-1:0] ost_cnt;
  logic pri_ready;
  logic [2:0] tk_s1, tk_s2, tk_s3, edges;
  logic run_s1, run_s2, sec_ready;
  logic wr_en, hit, halt_ok, sw_ok;
  logic [31:0] rd_mux;
  logic default_source_config, two_speed, wdt_en, mon_en, crystal_mode;

  assign default_source_config = cfg_reg[BIT_DEF_SRC];
  assign two_speed = cfg_reg[BIT_TWO_SPEED];
  assign wdt_en = cfg_reg[BIT_WDT_EN];
  assign mon_en = cfg_reg[BIT_MON_EN];
  assign crystal_mode = cfg_reg[BIT_CRYSTAL];

  // ----------------------------------------------------------------
  // oscillator synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk_s1 <= 3'h0;
      tk_s2 <= 3'h0;
      tk_s3 <= 3'h0;
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
    end else begin
      tk_s1 <= {int_osc_tick, sec_osc_tick, pri_osc_tick};
      tk_s2 <= tk_s1;
      tk_s3 <= tk_s2;
      run_s1 <= sec_osc_running;
      run_s2 <= run_s1;
    end
  end
  // rising edge of each source: bit0 primary, bit1 secondary, bit2 internal
  assign edges = tk_s2 & ~tk_s3;
  assign sec_ready = run_s2 & secondary_osc_enable;

  function automatic logic tick_of(input pmcs_src_t s, input logic [2:0] e);
    logic t;
    t = 1'b0;
    unique case (s)
      SRC_PRI: t = e[0];
      SRC_SEC: t = e[1];
      SRC_INT: t = e[2];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic ready_of(input pmcs_src_t s, input logic pr, input logic sr);
    logic r;
    r = 1'b0;
    unique case (s)
      SRC_PRI: r = pr;
      SRC_SEC: r = sr;
      SRC_INT: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // primary start-up counter
  // ----------------------------------------------------------------
  // external clock modes need no start-up wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt <= '0;
      pri_ready <= 1'b1;
    end else if (!pri_osc_en) begin
      ost_cnt <= '0;
      pri_ready <= 1'b0;
    end else if (!pri_ready) begin
      if (!crystal_mode) begin
        pri_ready <= 1'b1;
      end else if (edges[0]) begin
        if (ost_cnt == OW'(OST_LEN - 1)) begin
          pri_ready <= 1'b1;
        end else begin
          ost_cnt <= ost_cnt + OW'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    if (clock_source_select == 2'h0) begin
      tgt = default_source_config ? SRC_PRI : SRC_INT;
    end else begin
      tgt = pmcs_src_t'(clock_source_select);
    end
  end

  assign halt_ok = !(tgt == SRC_SEC && !secondary_osc_enable);
  // sec is entered even when not yet running; the pause then holds clocks
  assign sw_ok = halt_ok && (tgt == SRC_SEC || ready_of(tgt, pri_ready, sec_ready));

  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    dest_next = dest_reg;
    pcnt_next = pcnt_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (halt_req) begin
          if (!idle_on_halt) begin
            state_next = ST_SLEEP;
            cur_next = SRC_NONE;
          end else if (halt_ok) begin
            state_next = ST_IDLE;
          end
        end else if (tgt != cur_reg && sw_ok) begin
          // old source keeps clocking until the new one is ready, except that secondary is entered before it runs
          state_next = ST_SW_OLD;
          dest_next = tgt;
          pcnt_next = 2'h0;
        end
      end
      ST_SW_OLD: begin
        if (tick_of(cur_reg, edges)) begin
          if (pcnt_reg == 2'(OLD_PAUSE - 1)) begin
            state_next = ST_SW_NEW;
            pcnt_next = 2'h0;
          end else begin
            pcnt_next = pcnt_reg + 2'h1;
          end
        end
      end
      ST_SW_NEW: begin
        if (ready_of(dest_reg, pri_ready, sec_ready) && tick_of(dest_reg, edges)) begin
          if (pcnt_reg == 2'(NEW_PAUSE - 1)) begin
            state_next = ST_RUN;
            cur_next = dest_reg;
          end else begin
            pcnt_next = pcnt_reg + 2'h1;
          end
        end
      end
      ST_IDLE: begin
        if (wake_event) begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          if (two_speed || mon_en) begin
            state_next = ST_RUN;
            cur_next = SRC_INT;
          end else begin
            state_next = ST_SW_NEW;
            dest_next = halt_ok ? tgt : SRC_INT;
            pcnt_next = 2'h0;
          end
        end
      end
      default: begin
        state_next = ST_RUN;
        cur_next = SRC_INT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
      cur_reg <= SRC_PRI;
      dest_reg <= SRC_PRI;
      pcnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      dest_reg <= dest_next;
      pcnt_reg <= pcnt_next;
    end
  end

  // ----------------------------------------------------------------
  // clock gates, oscillator enables, status
  // ----------------------------------------------------------------
  // gates change only between source edges of a stopped mux: no runt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      clk_source <= SRC_PRI;
      primary_clock_active <= 1'b1;
      secondary_clock_active <= 1'b0;
    end else begin
      cpu_clk_en <= (state_next == ST_RUN);
      periph_clk_en <= (state_next == ST_RUN) || (state_next == ST_IDLE);
      clk_source <= cur_next;
      primary_clock_active <= (cur_next == SRC_PRI);
      secondary_clock_active <= (cur_next == SRC_SEC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_osc_en <= 1'b1;
      int_osc_en <= 1'b1;
      sec_osc_en <= 1'b0;
    end else begin
      pri_osc_en <= (state_next != ST_SLEEP) && ((cur_next == SRC_PRI) ||
        (dest_next == SRC_PRI && (state_next == ST_SW_OLD || state_next == ST_SW_NEW)) ||
        (tgt == SRC_PRI && state_next == ST_RUN));
      int_osc_en <= wdt_en || ((state_next != ST_SLEEP) &&
        (mon_en || cur_next == SRC_INT || dest_next == SRC_INT));
      sec_osc_en <= secondary_osc_enable;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, no wait state
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_OSC_CTRL: begin
        rd_mux[BIT_IDLE] = idle_on_halt;
        rd_mux[BIT_PRI_ACT] = primary_clock_active;
        rd_mux[BIT_SEL_LO +: 2] = clock_source_select;
      end
      OFF_TMR_CTRL: begin
        rd_mux[BIT_SEC_ACT] = secondary_clock_active;
        rd_mux[BIT_SEC_EN] = secondary_osc_enable;
      end
      OFF_CONFIG: rd_mux[4:0] = cfg_reg;
      OFF_STATUS: begin
        rd_mux[BIT_ST_LO +: 5] = state_reg;
        rd_mux[BIT_SRC_LO +: 2] = cur_reg;
        rd_mux[BIT_PRI_RDY] = pri_ready;
        rd_mux[BIT_SEC_RDY] = sec_ready;
      end
      default: hit = 1'b0;
    endcase
  end

  assign wr_en = psel && penable && pready && pwrite && hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // only software writes reach these fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_on_halt <= RST_IDLE;
      clock_source_select <= RST_SEL;
      secondary_osc_enable <= RST_SEC_EN;
      cfg_reg <= RST_CONFIG;
    end else if (wr_en) begin
      if (paddr == OFF_OSC_CTRL) begin
        idle_on_halt <= pwdata[BIT_IDLE];
        clock_source_select <= pwdata[BIT_SEL_LO +: 2];
      end
      if (paddr == OFF_TMR_CTRL) begin
        secondary_osc_enable <= pwdata[BIT_SEC_EN];
      end
      if (paddr == OFF_CONFIG) begin
        cfg_reg <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_entry: assert property (
    state_reg == ST_RUN && halt_req && !idle_on_halt |=> state_reg == ST_SLEEP && !cpu_clk_en
  ) else $error("halt with idle clear did not sleep");
  a_idle_entry: assert property (
    state_reg == ST_RUN && halt_req && idle_on_halt && halt_ok |=> state_reg == ST_IDLE
  ) else $error("halt with idle set did not idle");
  a_idle_clocks: assert property (
    state_reg == ST_IDLE |-> periph_clk_en && !cpu_clk_en && clk_source == $past(clk_source)
  ) else $error("idle clocking wrong");
  a_run_clocks: assert property (
    state_reg == ST_RUN |-> cpu_clk_en && periph_clk_en && clk_source != SRC_NONE
  ) else $error("run mode not fully clocked");
  a_sec_refused: assert property (
    state_reg == ST_RUN && tgt == SRC_SEC && !secondary_osc_enable && !halt_req
    |=> state_reg == ST_RUN && clk_source == $past(clk_source)
  ) else $error("secondary entered while disabled");
  a_pause_dark: assert property (
    state_reg == ST_SW_OLD || state_reg == ST_SW_NEW |-> !cpu_clk_en && !periph_clk_en
  ) else $error("clock gate open during pause");
  a_old_pause: assert property (
    state_reg == ST_SW_OLD && !(tick_of(cur_reg, edges) && pcnt_reg == 2'(OLD_PAUSE - 1))
    |=> state_reg == ST_SW_OLD
  ) else $error("pause left early");
  a_sleep_status: assert property (
    state_reg == ST_SLEEP |-> !primary_clock_active && !secondary_clock_active && !pri_osc_en
  ) else $error("sleep status or oscillator wrong");
  a_sleep_wdt: assert property (
    state_reg == ST_SLEEP && wdt_en |-> int_osc_en
  ) else $error("internal osc stopped with watchdog");
  a_status_excl: assert property (
    !(primary_clock_active && secondary_clock_active)
  ) else $error("both status bits set");
  a_sel_hold: assert property (
    !wr_en |=> $stable(clock_source_select) && $stable(idle_on_halt)
  ) else $error("select changed without write");
  a_ost_len: assert property (
    $rose(pri_ready) && crystal_mode |-> $past(ost_cnt) == OW'(OST_LEN - 1)
  ) else $error("primary ready before start-up count");

  c_sleep_wake: cover property (state_reg == ST_SLEEP ##[1:1000] state_reg == ST_RUN);
  c_idle_wake: cover property (state_reg == ST_IDLE ##1 state_reg == ST_RUN);
  c_to_sec: cover property ($rose(secondary_clock_active));
  c_to_int: cover property (state_reg == ST_SW_NEW && dest_reg == SRC_INT ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

/* src/pmcs_pkg.sv */
// constants, types and register map of the power mode clock switcher
//
// Summary of operation
// - halt picks Sleep when idle_on_halt is clear, Idle when it is set.
// - every halt re-reads idle_on_halt, so a changed setting takes effect.
// - Idle stops the CPU clock, peripherals run from the selected source.
// - writing clock_source_select switches at once when the new source runs.
// - a switch pauses the clock two old-source cycles plus three new-source cycles.
// - primary_clock_active and secondary_clock_active show the source; neither means internal or Sleep.
// - every Run mode clocks both CPU and peripherals.
// - after reset the device runs from primary with primary_clock_active set.
// - select 01 switches to secondary, stops primary, updates both status bits.
// - select 01 with secondary_osc_enable clear does not enter secondary run.
// - secondary enabled but not oscillating holds device clocks until it starts.
// - secondary to primary keeps secondary clocking until primary ready, then swaps.
// - select 11 switches to internal, stops primary, clears primary_clock_active.
// - internal to primary keeps internal clocking until primary ready.
// - hardware never changes idle_on_halt or clock_source_select.
// - internal oscillator stays on when watchdog is enabled, and outside Sleep when clock monitor is enabled.
// - Sleep stops oscillator and all clocks, clears both status bits, no switch.
// - in Sleep internal runs for watchdog, secondary runs if enabled.
// - wake from Sleep stays unclocked until ready, or runs internal if enabled.
// - after wake primary_clock_active sets once primary clocks the device.
// - select 00 means primary when default_source_config is 1, else internal.
// - every reset clears clock_source_select.
// - crystal primary is ready only after 1024 start-up cycles once re-enabled; reset marks it ready at once.
package pmcs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_TMR_CTRL = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  // oscillator_control_reg fields
  localparam int unsigned BIT_IDLE = 7;
  localparam int unsigned BIT_PRI_ACT = 3;
  localparam int unsigned BIT_SEL_LO = 0;
  // secondary_timer_control fields
  localparam int unsigned BIT_SEC_ACT = 6;
  localparam int unsigned BIT_SEC_EN = 3;
  // configuration fields
  localparam int unsigned BIT_DEF_SRC = 0;
  localparam int unsigned BIT_TWO_SPEED = 1;
  localparam int unsigned BIT_WDT_EN = 2;
  localparam int unsigned BIT_MON_EN = 3;
  localparam int unsigned BIT_CRYSTAL = 4;
  // status fields
  localparam int unsigned BIT_ST_LO = 0;
  localparam int unsigned BIT_SRC_LO = 8;
  localparam int unsigned BIT_PRI_RDY = 10;
  localparam int unsigned BIT_SEC_RDY = 11;
  // reset values
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_IDLE = 1'b0;
  localparam logic RST_SEC_EN = 1'b0;
  localparam logic [4:0] RST_CONFIG = 5'h11;
  // counts in source cycles
  localparam int unsigned OST_CYCLES = 1024;
  localparam int unsigned OLD_PAUSE = 2;
  localparam int unsigned NEW_PAUSE = 3;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_SEC = 2'h1,
    SRC_PRI = 2'h2,
    SRC_INT = 2'h3
  } pmcs_src_t;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_SW_OLD = 5'h02,
    ST_SW_NEW = 5'h04,
    ST_IDLE = 5'h08,
    ST_SLEEP = 5'h10
  } pmcs_state_t;
endpackage

/* verification/test_pmcs_top.sv */
// self-checking bench for the power mode clock switcher
`timescale 1ns/100ps
`default_nettype none
module test_pmcs_top
  import pmcs_pkg::*;
;
  localparam int unsigned OST_SMALL = 4;
  logic pclk, presetn, psel, penable, pwrite, halt_req, wake_event;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sec_osc_running;
  // models start low, else their toggles stay unknown for ever
  logic pri_osc_tick = 1'b0;
  logic sec_osc_tick = 1'b0;
  logic int_osc_tick = 1'b0;
  logic cpu_clk_en, periph_clk_en, pri_osc_en, sec_osc_en, int_osc_en;
  logic primary_clock_active, secondary_clock_active;
  logic [1:0] clk_source;
  int num_errors = 0;
  int n_compared = 0;
  int pri_cnt = 0;
  int sec_cnt = 0;
  int int_cnt = 0;
  int n_wait;

  pmcs_top #(.OST_LEN(OST_SMALL)) i_pmcs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_req(halt_req), .wake_event(wake_event), .pri_osc_tick(pri_osc_tick),
    .sec_osc_tick(sec_osc_tick), .int_osc_tick(int_osc_tick),
    .sec_osc_running(sec_osc_running), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .clk_source(clk_source), .pri_osc_en(pri_osc_en),
    .sec_osc_en(sec_osc_en), .int_osc_en(int_osc_en),
    .primary_clock_active(primary_clock_active),
    .secondary_clock_active(secondary_clock_active));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // oscillators: periods 8, 12 and 10 pclk
  // ----------------------------------------
  // a stopped oscillator sits low, so a design that keeps counting it hangs
  always @(posedge pclk) begin
    pri_cnt <= (pri_cnt == 3) ? 0 : pri_cnt + 1;
    sec_cnt <= (sec_cnt == 5) ? 0 : sec_cnt + 1;
    int_cnt <= (int_cnt == 4) ? 0 : int_cnt + 1;
    if (pri_osc_en !== 1'b1) pri_osc_tick <= 1'b0;
    else if (pri_cnt == 3) pri_osc_tick <= ~pri_osc_tick;
    if (sec_osc_en !== 1'b1 || sec_osc_running !== 1'b1) sec_osc_tick <= 1'b0;
    else if (sec_cnt == 5) sec_osc_tick <= ~sec_osc_tick;
    if (int_osc_en !== 1'b1) int_osc_tick <= 1'b0;
    else if (int_cnt == 4) int_osc_tick <= ~int_osc_tick;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bit_chk(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    bit_chk(e, 1'b0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    bit_chk(e, err);
  endtask

  task wait_src(input logic [1:0] s);
    n_wait = 0;
    while (clk_source !== s && n_wait < 3000) begin
      @(posedge pclk);
      n_wait++;
    end
    check({30'h0, clk_source}, {30'h0, s});
  endtask

  task wait_cpu;
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    bit_chk(cpu_clk_en, 1'b1);
  endtask

  // both gates must stay low for the whole pause
  task measure_pause;
    int n;
    logic leak;
    n = 0;
    leak = 1'b0;
    while (cpu_clk_en !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 300) begin
      if (periph_clk_en !== 1'b0) leak = 1'b1;
      @(posedge pclk);
      n++;
    end
    bit_chk(leak, 1'b0);
    bit_chk(n >= 20 && n <= 70, 1'b1);
  endtask

  task pulse(input logic is_halt);
    if (is_halt) halt_req <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_event <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, halt_req, wake_event, sec_osc_running} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_OSC_CTRL, 32'h08, 1'b0);
    bit_chk(primary_clock_active, 1'b1);
    check({30'h0, clk_source}, {30'h0, SRC_PRI});
    bit_chk(cpu_clk_en & periph_clk_en, 1'b1);
    rd(8'h10, 32'h0, 1'b1);
    $display("test reset done");
    wr(OFF_CONFIG, 32'h15);
    wr(OFF_OSC_CTRL, 32'h03);
    measure_pause;
    wait_src(SRC_INT);
    bit_chk(primary_clock_active | secondary_clock_active, 1'b0);
    bit_chk(pri_osc_en, 1'b0);
    rd(OFF_OSC_CTRL, 32'h03, 1'b0);
    wr(OFF_OSC_CTRL, 32'h02);
    check({30'h0, clk_source}, {30'h0, SRC_INT});
    wait_src(SRC_PRI);
    bit_chk(n_wait >= 44, 1'b1);
    bit_chk(primary_clock_active, 1'b1);
    bit_chk(int_osc_en, 1'b1);
    $display("test internal run done");
    wr(OFF_OSC_CTRL, 32'h01);
    repeat (40) @(posedge pclk);
    check({30'h0, clk_source}, {30'h0, SRC_PRI});
    wr(OFF_TMR_CTRL, 32'h08);
    repeat (60) @(posedge pclk);
    bit_chk(cpu_clk_en, 1'b0);
    sec_osc_running <= 1'b1;
    wait_src(SRC_SEC);
    bit_chk(secondary_clock_active & ~primary_clock_active, 1'b1);
    bit_chk(pri_osc_en, 1'b0);
    rd(OFF_TMR_CTRL, 32'h48, 1'b0);
    wr(OFF_OSC_CTRL, 32'h02);
    check({30'h0, clk_source}, {30'h0, SRC_SEC});
    wait_src(SRC_PRI);
    bit_chk(primary_clock_active & ~secondary_clock_active, 1'b1);
    bit_chk(sec_osc_en, 1'b1);
    $display("test secondary run done");
    wr(OFF_OSC_CTRL, 32'h82);
    pulse(1'b1);
    bit_chk(cpu_clk_en, 1'b0);
    bit_chk(periph_clk_en, 1'b1);
    check({30'h0, clk_source}, {30'h0, SRC_PRI});
    pulse(1'b0);
    wait_cpu;
    rd(OFF_OSC_CTRL, 32'h8A, 1'b0);
    $display("test idle done");
    wr(OFF_OSC_CTRL, 32'h02);
    pulse(1'b1);
    bit_chk(cpu_clk_en | periph_clk_en, 1'b0);
    bit_chk(primary_clock_active | secondary_clock_active, 1'b0);
    bit_chk(pri_osc_en, 1'b0);
    bit_chk(sec_osc_en & int_osc_en, 1'b1);
    pulse(1'b0);
    bit_chk(cpu_clk_en, 1'b0);
    wait_cpu;
    bit_chk(primary_clock_active, 1'b1);
    $display("test sleep done");
    wr(OFF_CONFIG, 32'h14);
    wr(OFF_OSC_CTRL, 32'h00);
    wait_src(SRC_INT);
    wr(OFF_OSC_CTRL, 32'h83);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_OSC_CTRL, 32'h08, 1'b0);
    $display("test default source done");
    check({30'h0, clk_source}, {30'h0, SRC_PRI});
    wr(OFF_CONFIG, 32'h13);
    pulse(1'b1);
    pulse(1'b0);
    check({30'h0, clk_source}, {30'h0, SRC_INT});
    bit_chk(cpu_clk_en & ~primary_clock_active, 1'b1);
    wait_src(SRC_PRI);
    bit_chk(primary_clock_active, 1'b1);
    $display("test two-speed wake done");
    wrap_up;
  end

  // whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
